/* rtl/sirq_dev.sv */
// Device end of the serial interrupt link: reports six interrupt sources.
// Assumes the host end shares clk_sys and drives frames as below.

`timescale 1ns/1ps

module sirq_dev #(
	parameter int NUM_FRAMES = sirq_pkg::NUM_FRAMES
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic irq_kbd,
	input wire logic irq_ser2,
	input wire logic irq_ser1,
	input wire logic irq_fdd,
	input wire logic irq_lpt,
	input wire logic irq_mouse,
	sirq_if.dev link,
	output logic quiet_mode,
	output logic cycle_busy,
	output logic stop_err
);

	localparam int FW = $clog2(NUM_FRAMES);

	typedef enum logic [2:0] {
		DS_IDLE,
		DS_START,
		DS_LEAD,
		DS_FRAME,
		DS_STOP_WAIT,
		DS_STOP_LOW
	} sirq_dev_state_t;

	// ------------------------------------------------------------
	// Source synchronisers
	// ------------------------------------------------------------
	logic [sirq_pkg::NUM_SRC-1:0] src_meta_ff;
	logic [sirq_pkg::NUM_SRC-1:0] src_sync_ff;
	logic [sirq_pkg::NUM_SRC-1:0] nxt_src_meta;
	logic [sirq_pkg::NUM_SRC-1:0] nxt_src_sync;

	always_comb begin
		nxt_src_meta = {irq_mouse, irq_lpt, irq_fdd, irq_ser1, irq_ser2, irq_kbd};
		nxt_src_sync = src_meta_ff;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			src_meta_ff <= '0;
			src_sync_ff <= '0;
		end else if (clk_en) begin
			src_meta_ff <= nxt_src_meta;
			src_sync_ff <= nxt_src_sync;
		end
	end

	// ------------------------------------------------------------
	// Frame request map
	// ------------------------------------------------------------
	// sources to frames
	function automatic logic [NUM_FRAMES-1:0] map_req(input logic [sirq_pkg::NUM_SRC-1:0] s);
		logic [NUM_FRAMES-1:0] v;
		v = '0;
		v[sirq_pkg::FR_KBD] = s[0];
		v[sirq_pkg::FR_SER2] = s[1];
		v[sirq_pkg::FR_SER1] = s[2];
		v[sirq_pkg::FR_FDD] = s[3];
		v[sirq_pkg::FR_LPT] = s[4];
		v[sirq_pkg::FR_MOUSE] = s[5];
		return v;
	endfunction

	logic [NUM_FRAMES-1:0] req_vec;
	logic any_pending;

	assign req_vec = map_req(src_sync_ff);
	assign any_pending = |src_sync_ff;

	// ------------------------------------------------------------
	// Cycle sequencer
	// ------------------------------------------------------------
	sirq_dev_state_t state_ff;
	sirq_dev_state_t nxt_state;
	sirq_pkg::sirq_phase_t phase_ff;
	sirq_pkg::sirq_phase_t nxt_phase;
	logic [FW-1:0] frame_ff;
	logic [FW-1:0] nxt_frame;
	logic [FW-1:0] frame_inc;
	logic [3:0] low_ff;
	logic [3:0] nxt_low;
	logic quiet_ff;
	logic nxt_quiet;
	logic o_ff;
	logic nxt_o;
	logic oe_n_ff;
	logic nxt_oe_n;
	logic busy_ff;
	logic nxt_busy;
	logic err_ff;
	logic nxt_err;

	assign frame_inc = frame_ff + FW'(1);

	always_comb begin
		nxt_state = state_ff;
		nxt_phase = phase_ff;
		nxt_frame = frame_ff;
		nxt_low = low_ff;
		nxt_quiet = quiet_ff;
		nxt_err = err_ff;
		nxt_o = 1'b1;
		nxt_oe_n = 1'b1;
		case (state_ff)
			DS_IDLE: begin
				if (!link.line) begin
					nxt_state = DS_START;
				end else if (quiet_ff && any_pending) begin
					nxt_state = DS_START;
					nxt_o = 1'b0;
					nxt_oe_n = 1'b0;
				end
			end
			DS_START: begin
				if (link.line) begin
					nxt_state = DS_LEAD;
				end
			end
			DS_LEAD: begin
				nxt_state = DS_FRAME;
				nxt_phase = sirq_pkg::PH_SAMPLE;
				nxt_frame = '0;
				nxt_o = 1'b0;
				nxt_oe_n = !req_vec[0];
			end
			DS_FRAME: begin
				case (phase_ff)
					sirq_pkg::PH_SAMPLE: begin
						nxt_phase = sirq_pkg::PH_RECOV;
						nxt_oe_n = oe_n_ff;
					end
					sirq_pkg::PH_RECOV: begin
						nxt_phase = sirq_pkg::PH_TURN;
					end
					default: begin
						if (frame_ff == FW'(NUM_FRAMES - 1)) begin
							nxt_state = DS_STOP_WAIT;
						end else begin
							nxt_phase = sirq_pkg::PH_SAMPLE;
							nxt_frame = frame_inc;
							nxt_o = 1'b0;
							nxt_oe_n = !req_vec[frame_inc];
						end
					end
				endcase
			end
			DS_STOP_WAIT: begin
				if (!link.line) begin
					nxt_state = DS_STOP_LOW;
					nxt_low = 4'h1;
				end
			end
			DS_STOP_LOW: begin
				if (!link.line) begin
					if (low_ff != 4'hf) begin
						nxt_low = low_ff + 4'h1;
					end
				end else begin
					nxt_quiet = (low_ff == sirq_pkg::STOP_LEN_QUIET);
					nxt_err = (low_ff != sirq_pkg::STOP_LEN_QUIET) &&
						(low_ff != sirq_pkg::STOP_LEN_CONT);
					nxt_state = DS_IDLE;
				end
			end
			default: begin
				nxt_state = DS_IDLE;
			end
		endcase
		nxt_busy = (nxt_state != DS_IDLE);
	end

	// Outputs change only on rising edges, straight from flops
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_ff <= DS_IDLE;
			phase_ff <= sirq_pkg::PH_SAMPLE;
			frame_ff <= '0;
			low_ff <= 4'h0;
			quiet_ff <= sirq_pkg::QUIET_RST;
			o_ff <= 1'b1;
			oe_n_ff <= 1'b1;
			busy_ff <= 1'b0;
			err_ff <= 1'b0;
		end else if (clk_en) begin
			state_ff <= nxt_state;
			phase_ff <= nxt_phase;
			frame_ff <= nxt_frame;
			low_ff <= nxt_low;
			quiet_ff <= nxt_quiet;
			o_ff <= nxt_o;
			oe_n_ff <= nxt_oe_n;
			busy_ff <= nxt_busy;
			err_ff <= nxt_err;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign link.dev_o = o_ff;
	assign link.dev_oe_n = oe_n_ff;
	assign quiet_mode = quiet_ff;
	assign cycle_busy = busy_ff;
	assign stop_err = err_ff;

endmodule

/* rtl/sirq_host.sv */
// Host end of the serial interrupt link: frames cycles, collects frames.
// Assumes devices on the line share clk_sys; line needs no synchroniser.

`timescale 1ns/1ps

module sirq_host #(
	parameter int NUM_FRAMES = sirq_pkg::NUM_FRAMES
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic start_req,
	input wire logic [2:0] cfg_start_extra,
	input wire logic cfg_quiet_next,
	sirq_if.host link,
	output logic [NUM_FRAMES-1:0] irq_frames,
	output logic frames_valid,
	output logic quiet_mode
);

	localparam int FW = $clog2(NUM_FRAMES);

	typedef enum logic [2:0] {
		HS_IDLE,
		HS_START_LOW,
		HS_START_HI,
		HS_LEAD,
		HS_FRAME,
		HS_STOP_LOW,
		HS_STOP_HI
	} sirq_host_state_t;

	// ------------------------------------------------------------
	// Start length
	// ------------------------------------------------------------
	logic [3:0] extra;

	always_comb begin
		extra = {1'b0, cfg_start_extra};
		if (extra < sirq_pkg::START_EXTRA_MIN) begin
			extra = sirq_pkg::START_EXTRA_MIN;
		end
	end

	// ------------------------------------------------------------
	// Cycle sequencer
	// ------------------------------------------------------------
	sirq_host_state_t state_ff;
	sirq_host_state_t nxt_state;
	sirq_pkg::sirq_phase_t phase_ff;
	sirq_pkg::sirq_phase_t nxt_phase;
	logic [FW-1:0] frame_ff;
	logic [FW-1:0] nxt_frame;
	logic [3:0] cnt_ff;
	logic [3:0] nxt_cnt;
	logic [NUM_FRAMES-1:0] cap_ff;
	logic [NUM_FRAMES-1:0] nxt_cap;
	logic [NUM_FRAMES-1:0] out_ff;
	logic [NUM_FRAMES-1:0] nxt_out;
	logic quiet_ff;
	logic nxt_quiet;
	logic sel_ff;
	logic nxt_sel;
	logic valid_ff;
	logic nxt_valid;
	logic o_ff;
	logic nxt_o;
	logic oe_n_ff;
	logic nxt_oe_n;

	always_comb begin
		nxt_state = state_ff;
		nxt_phase = phase_ff;
		nxt_frame = frame_ff;
		nxt_cnt = cnt_ff;
		nxt_cap = cap_ff;
		nxt_out = out_ff;
		nxt_quiet = quiet_ff;
		nxt_sel = sel_ff;
		nxt_valid = 1'b0;
		nxt_o = 1'b1;
		nxt_oe_n = 1'b1;
		case (state_ff)
			HS_IDLE: begin
				if (quiet_ff ? !link.line : start_req) begin
					// Quiet: device gave the first clock already
					nxt_state = HS_START_LOW;
					nxt_cnt = quiet_ff ? extra : extra + 4'h1;
					nxt_o = 1'b0;
					nxt_oe_n = 1'b0;
				end
			end
			HS_START_LOW: begin
				nxt_o = 1'b0;
				nxt_oe_n = 1'b0;
				if (cnt_ff == 4'h1) begin
					nxt_state = HS_START_HI;
					nxt_o = 1'b1;
				end else begin
					nxt_cnt = cnt_ff - 4'h1;
				end
			end
			HS_START_HI: begin
				nxt_state = HS_LEAD;
			end
			HS_LEAD: begin
				nxt_state = HS_FRAME;
				nxt_phase = sirq_pkg::PH_SAMPLE;
				nxt_frame = '0;
				nxt_cap = '0;
			end
			HS_FRAME: begin
				case (phase_ff)
					sirq_pkg::PH_SAMPLE: begin
						nxt_cap[frame_ff] = !link.line;
						nxt_phase = sirq_pkg::PH_RECOV;
					end
					sirq_pkg::PH_RECOV: begin
						nxt_phase = sirq_pkg::PH_TURN;
					end
					default: begin
						if (frame_ff == FW'(NUM_FRAMES - 1)) begin
							nxt_state = HS_STOP_LOW;
							nxt_sel = cfg_quiet_next;
							nxt_cnt = cfg_quiet_next ? sirq_pkg::STOP_LEN_QUIET :
								sirq_pkg::STOP_LEN_CONT;
							nxt_o = 1'b0;
							nxt_oe_n = 1'b0;
						end else begin
							nxt_phase = sirq_pkg::PH_SAMPLE;
							nxt_frame = frame_ff + FW'(1);
						end
					end
				endcase
			end
			HS_STOP_LOW: begin
				nxt_o = 1'b0;
				nxt_oe_n = 1'b0;
				if (cnt_ff == 4'h1) begin
					nxt_state = HS_STOP_HI;
					nxt_o = 1'b1;
				end else begin
					nxt_cnt = cnt_ff - 4'h1;
				end
			end
			HS_STOP_HI: begin
				nxt_state = HS_IDLE;
				nxt_quiet = sel_ff;
				nxt_out = cap_ff;
				nxt_valid = 1'b1;
			end
			default: begin
				nxt_state = HS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_ff <= HS_IDLE;
			phase_ff <= sirq_pkg::PH_SAMPLE;
			frame_ff <= '0;
			cnt_ff <= 4'h0;
			cap_ff <= '0;
			out_ff <= '0;
			quiet_ff <= sirq_pkg::QUIET_RST;
			sel_ff <= sirq_pkg::QUIET_RST;
			valid_ff <= 1'b0;
			o_ff <= 1'b1;
			oe_n_ff <= 1'b1;
		end else if (clk_en) begin
			state_ff <= nxt_state;
			phase_ff <= nxt_phase;
			frame_ff <= nxt_frame;
			cnt_ff <= nxt_cnt;
			cap_ff <= nxt_cap;
			out_ff <= nxt_out;
			quiet_ff <= nxt_quiet;
			sel_ff <= nxt_sel;
			valid_ff <= nxt_valid;
			o_ff <= nxt_o;
			oe_n_ff <= nxt_oe_n;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign link.host_o = o_ff;
	assign link.host_oe_n = oe_n_ff;
	assign irq_frames = out_ff;
	assign frames_valid = valid_ff;
	assign quiet_mode = quiet_ff;

endmodule

/* rtl/sirq_if.sv */
// Shared serial interrupt line joining the device end and the host end.
// Assumes a pull-up: the line is high unless an enabled driver pulls it low.

`timescale 1ns/1ps

interface sirq_if;
	logic dev_o;
	logic dev_oe_n;
	logic host_o;
	logic host_oe_n;
	logic line;

	// Wired-and of the two drivers; released pins read as pulled high
	assign line = !((!dev_oe_n && !dev_o) || (!host_oe_n && !host_o));

	modport dev (output dev_o, output dev_oe_n, input line);
	modport host (output host_o, output host_oe_n, input line);
endinterface

/* rtl/sirq_pkg.sv */
// Shared constants and types for both ends of the serial interrupt link.
// Assumes both ends and the shared line run on one common PCI clock.

package sirq_pkg;

	// ------------------------------------------------------------
	// Frame layout
	// ------------------------------------------------------------
	localparam int NUM_FRAMES = 32;
	localparam int SAMPLE_OFS = 2;
	localparam int FRAME_CLKS = 3;
	localparam int FR_KBD = 1;
	localparam int FR_SER2 = 3;
	localparam int FR_SER1 = 4;
	localparam int FR_FDD = 6;
	localparam int FR_LPT = 7;
	localparam int FR_MOUSE = 12;
	localparam int NUM_SRC = 6;

	// ------------------------------------------------------------
	// Pulse lengths in clocks
	// ------------------------------------------------------------
	localparam logic [3:0] START_EXTRA_MIN = 4'h3;
	localparam logic [3:0] START_EXTRA_MAX = 4'h7;
	localparam logic [3:0] STOP_LEN_QUIET = 4'h2;
	localparam logic [3:0] STOP_LEN_CONT = 4'h3;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic QUIET_RST = 1'b0;

	typedef enum logic [1:0] {PH_SAMPLE, PH_RECOV, PH_TURN} sirq_phase_t;

endpackage

/* testbench/serial_irq_slave_tb.sv */
// Testbench joining device and host ends over one shared line.
// Assumes the package and interface from rtl/ are compiled first.

`timescale 1ns/1ps

module serial_irq_slave_tb;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic start_req = 1'b0;
	logic [2:0] cfg_start_extra = 3'h0;
	logic cfg_quiet_next = 1'b0;
	// Bits: kbd, ser2, ser1, fdd, lpt, mouse
	logic [5:0] src = 6'h3f;
	logic [31:0] irq_frames;
	logic frames_valid, host_quiet, dev_quiet, dev_busy, stop_err;
	int failures = 0;
	int n_checks = 0;
	int cycles = 0;

	sirq_if sirq_if_i ();
	sirq_dev sirq_dev_i (.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1), .irq_kbd(src[0]),
		.irq_ser2(src[1]), .irq_ser1(src[2]), .irq_fdd(src[3]), .irq_lpt(src[4]),
		.irq_mouse(src[5]), .link(sirq_if_i), .quiet_mode(dev_quiet), .cycle_busy(dev_busy),
		.stop_err(stop_err));
	sirq_host sirq_host_i (.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1), .start_req(start_req),
		.cfg_start_extra(cfg_start_extra), .cfg_quiet_next(cfg_quiet_next), .link(sirq_if_i),
		.irq_frames(irq_frames), .frames_valid(frames_valid), .quiet_mode(host_quiet));
	sirq_link_checker #(.NUM_FRAMES(32)) sirq_link_checker_i (.clk_sys(clk_sys), .rst(rst),
		.dev_o(sirq_if_i.dev_o), .dev_oe_n(sirq_if_i.dev_oe_n), .host_o(sirq_if_i.host_o),
		.host_oe_n(sirq_if_i.host_oe_n), .line(sirq_if_i.line));

	always #20 clk_sys = ~clk_sys;

	// ----
	// Helpers
	// ----
	function automatic logic [31:0] fr(input logic [5:0] s);
		logic [31:0] f;
		f = 32'h0;
		f[sirq_pkg::FR_KBD] = s[0];
		f[sirq_pkg::FR_SER2] = s[1];
		f[sirq_pkg::FR_SER1] = s[2];
		f[sirq_pkg::FR_FDD] = s[3];
		f[sirq_pkg::FR_LPT] = s[4];
		f[sirq_pkg::FR_MOUSE] = s[5];
		return f;
	endfunction

	task automatic chk_bit(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_vec(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Bounded wait: a lost cycle shows as a missed pulse
	task automatic run_cycle(input logic req, input logic [2:0] ext, input logic qn,
		input logic [31:0] exp);
		int i;
		@(posedge clk_sys);
		cfg_start_extra <= ext;
		cfg_quiet_next <= qn;
		start_req <= req;
		@(posedge clk_sys);
		start_req <= 1'b0;
		#1;
		i = 0;
		while (frames_valid !== 1'b1 && i < 400) begin
			@(posedge clk_sys);
			#1;
			i++;
		end
		chk_bit(frames_valid, 1'b1);
		chk_vec(irq_frames, exp);
		chk_bit(host_quiet, qn);
		chk_bit(dev_quiet, qn);
		chk_bit(stop_err, 1'b0);
	endtask

	task automatic idle_chk;
		repeat (20) @(posedge clk_sys);
		#1;
		chk_bit(dev_busy, 1'b0);
	endtask

	task automatic complete_run;
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 2000) begin
			failures++;
			complete_run();
		end
	end

	// ----
	// Tests
	// ----
	initial begin
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		#1;
		chk_bit(dev_quiet, 1'b0);
		chk_bit(host_quiet, 1'b0);
		chk_vec(irq_frames, 32'h0);
		idle_chk();
		$display("test reset done");
		// Extra of zero is lifted to the minimum
		run_cycle(1'b1, 3'h0, 1'b0, fr(6'h3f));
		$display("test continuous done");
		run_cycle(1'b1, 3'h7, 1'b1, fr(6'h3f));
		$display("test to quiet done");
		// Device starts this one by itself
		run_cycle(1'b0, 3'h3, 1'b0, fr(6'h3f));
		idle_chk();
		$display("test device start done");
		@(posedge clk_sys);
		src <= 6'h00;
		run_cycle(1'b1, 3'h5, 1'b1, 32'h0);
		idle_chk();
		$display("test quiet no request done");
		@(posedge clk_sys);
		src <= 6'h14;
		run_cycle(1'b0, 3'h3, 1'b0, fr(6'h14));
		$display("test quiet pending done");
		complete_run();
	end
endmodule

/* testbench/sirq_link_checker.sv */
// Checker for the shared serial interrupt line between both ends.
// Assumes one clk_sys domain and the line signals of sirq_if.

`timescale 1ns/1ps

module sirq_link_checker #(
	parameter int NUM_FRAMES = 32
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic dev_o,
	input wire logic dev_oe_n,
	input wire logic host_o,
	input wire logic host_oe_n,
	input wire logic line
);
	// ----
	// Frame tracking
	// ----
	logic [3:0] run_ff, nxt_run;
	logic [7:0] pos_ff, nxt_pos;
	logic in_fr_ff, nxt_in_fr;
	logic host_high, dev_low;

	assign host_high = !host_oe_n && host_o;
	assign dev_low = !dev_oe_n && !dev_o;

	always_comb begin
		nxt_run = line ? 4'h0 : ((run_ff == 4'hf) ? run_ff : run_ff + 4'h1);
		nxt_pos = host_high ? 8'h01 : ((pos_ff == 8'hff) ? pos_ff : pos_ff + 8'h01);
		// Start pulse is 4 or more low, stop is shorter
		nxt_in_fr = host_high ? (!in_fr_ff && run_ff >= 4'h4) : in_fr_ff;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			run_ff <= 4'h0;
			pos_ff <= 8'h00;
			in_fr_ff <= 1'b0;
		end else begin
			run_ff <= nxt_run;
			pos_ff <= nxt_pos;
			in_fr_ff <= nxt_in_fr;
		end
	end

	// ----
	// Properties
	// ----
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	a_no_overlap: assert property (!(!dev_oe_n && !host_oe_n))
		else $error("both ends drive the line");
	a_quiet_start: assert property (dev_low ##1 !host_oe_n |-> dev_oe_n)
		else $error("device kept driving after start clock");
	a_recov_high: assert property (dev_low ##1 host_oe_n |-> (!dev_oe_n && dev_o) ##1 dev_oe_n)
		else $error("recovery or turn-around wrong");
	a_start_len: assert property (host_high && !in_fr_ff |-> run_ff inside {[4:8]})
		else $error("start pulse length wrong");
	a_stop_len: assert property (host_high && in_fr_ff |-> run_ff inside {[2:3]})
		else $error("stop pulse length wrong");
	a_host_one_high: assert property (host_high |=> host_oe_n)
		else $error("host high not one clock");
	a_sample_slot: assert property (in_fr_ff && dev_low |-> pos_ff % 3 == 2 && pos_ff < 2 + 3 * NUM_FRAMES)
		else $error("device low outside a sample clock");
	a_stop_pos: assert property ($fell(host_oe_n) && in_fr_ff |-> pos_ff == 2 + 3 * NUM_FRAMES)
		else $error("stop not after last frame");
	a_first_rel: assert property (in_fr_ff && pos_ff == 8'h01 |-> dev_oe_n && host_oe_n)
		else $error("line driven before first frame");
	a_reset_cont: assert property ($fell(rst) |-> dev_oe_n [*8])
		else $error("device started after reset");

	c_stop_quiet: cover property (host_high && in_fr_ff && run_ff == 4'h2);
	c_stop_cont: cover property (host_high && in_fr_ff && run_ff == 4'h3);
	c_dev_start: cover property (dev_low ##1 !host_oe_n);
	c_long_start: cover property (host_high && !in_fr_ff && run_ff == 4'h8);
endmodule
